// ---- hw/tx_fmt_map.svh ----
// constants of the per-channel transmit formatter
`ifndef TX_FMT_MAP_SVH
`define TX_FMT_MAP_SVH
`define TXF_FLAG_CHAR  8'h7E
`define TXF_ONES_CHAR  8'hFF
`define TXF_ABORT_CHAR 8'h7F
`define TXF_STUFF_RUN  3'h5
`define TXF_ADJ_SHIFT  3
`define TXF_OCT_BITS   3'h7
`define TXF_RST_CHAN   5'h0
`endif

// ---- hw/tx_fmt_pkg.sv ----
// types shared by the transmit formatter files
package tx_fmt_pkg;
	typedef struct packed {
		logic       transparent;
		logic       flag_adjust_enable;
		logic       fill_char_select;
		logic [7:0] slot_fill_char;
		logic       channel_tx_hold_cmd;
		logic       normal_abort;
		logic       fast_abort;
	} cfg_s;
	typedef struct packed {
		logic [7:0] data;
		logic       frame_end_bit;
		logic [7:0] interframe_fill_count;
	} tx_byte_s;
	typedef enum logic [1:0] {ST_FILL, ST_DATA, ST_LAST, ST_GAP} fmt_state_e;
	typedef enum logic [1:0] {EVT_NONE, EVT_FRAME_END, EVT_ABORT_UNDERRUN, EVT_ABORT_CMD} tx_evt_e;
endpackage : tx_fmt_pkg

// ---- hw/zero_insert_tracker.sv ----
// ones-run tracker and per-frame zero insertion counter
`timescale 1ns/1ps
`default_nettype none
`include "tx_fmt_map.svh"
module zero_insert_tracker #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	// bit events
	input  wire logic             sent_i,
	input  wire logic             bit_i,
	input  wire logic             content_i,
	input  wire logic             stuffed_i,
	input  wire logic             frame_start_i,
	// results
	output logic                  stuff_now_o,
	output logic [CNT_W-1:0]      zero_count_o
);
	logic [2:0] ones_reg;

	// run of ones inside frame content only, flags and fill reset it
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			ones_reg <= 3'h0;
		else if (stuffed_i || (sent_i && (!content_i || !bit_i)))
			ones_reg <= 3'h0;
		else if (sent_i)
			ones_reg <= ones_reg + 3'h1;
	end

	// count saturates so a huge frame cannot wrap back to no reduction
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			zero_count_o <= '0;
		else if (frame_start_i)
			zero_count_o <= '0;
		else if (stuffed_i && !(&zero_count_o))
			zero_count_o <= zero_count_o + 1'b1;
	end

	assign stuff_now_o = (ones_reg == `TXF_STUFF_RUN);
endmodule : zero_insert_tracker
`default_nettype wire

// ---- hw/channel_tx_formatter_hold.sv ----
// per-channel hdlc and transparent transmit formatter with hold and abort
`timescale 1ns/1ps
`default_nettype none
`include "tx_fmt_map.svh"
module channel_tx_formatter_hold #(
	parameter logic [4:0] CHANNEL_ID = `TXF_RST_CHAN
) (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	// action request and configuration
	input  wire logic                  action_request_pulse_n_i,
	input  wire tx_fmt_pkg::cfg_s      cfg_i,
	output logic                       action_ack_o,
	output logic                       desc_abort_close_o,
	// dma side
	input  wire logic                  desc_hold_i,
	output logic                       data_req_o,
	// byte input from the transmit buffer
	input  wire logic                  in_valid_i,
	input  wire tx_fmt_pkg::tx_byte_s  in_byte_i,
	output logic                       in_ready_o,
	// serial line
	input  wire logic                  bit_en_i,
	output logic                       tx_bit_o,
	// events
	output logic                       evt_valid_o,
	output tx_fmt_pkg::tx_evt_e        evt_code_o,
	output logic [4:0]                 evt_channel_o
);
	import tx_fmt_pkg::*;

	cfg_s       cfg_reg;
	fmt_state_e state_reg;
	fmt_state_e state_next;
	tx_byte_s   staged_reg;
	logic       staged_valid_reg;
	logic       staged_valid_next;
	logic [7:0] shift_reg;
	logic [2:0] bits_left_reg;
	logic       content_reg;
	logic [7:0] gap_reg;
	logic [7:0] gap_next;
	logic [7:0] frame_fill_reg;
	logic       ar_meta_reg;
	logic       ar_sync_reg;
	logic       ar_prev_reg;
	logic       ar_event;
	logic       stuff_now;
	logic [7:0] zero_count;
	logic       insert_zero;
	logic       oct_end;
	logic [7:0] oct_val;
	logic       oct_content;
	logic       take_data;
	logic       start_ok;
	logic       frame_start;
	logic       take;
	tx_evt_e    evt_next;

	// fill octet between frames; hdlc flag or ones by select, transparent the slot char with flag adjust set, else ones
	function automatic logic [7:0] fill_char(input cfg_s c);
		if (c.transparent)
			fill_char = c.flag_adjust_enable ? c.slot_fill_char : `TXF_ONES_CHAR;
		else
			fill_char = c.fill_char_select ? `TXF_ONES_CHAR : `TXF_FLAG_CHAR;
	endfunction : fill_char

	// reduction is the floor of zeros over eight, clamped at zero
	function automatic logic [7:0] adj_fill(input logic fa, input logic [7:0] fc,
			input logic [7:0] zc);
		logic [7:0] red;
		red = zc >> `TXF_ADJ_SHIFT;
		if (!fa)
			adj_fill = fc;
		else
			adj_fill = (fc > red) ? fc - red : 8'h00;
	endfunction : adj_fill

	// action request is a host pin, two flops before the falling-edge detect
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ar_meta_reg <= 1'b1;
			ar_sync_reg <= 1'b1;
			ar_prev_reg <= 1'b1;
		end else begin
			ar_meta_reg <= action_request_pulse_n_i;
			ar_sync_reg <= ar_meta_reg;
			ar_prev_reg <= ar_sync_reg;
		end
	end
	assign ar_event = ar_prev_reg && !ar_sync_reg;

	// configuration is taken whole on an action and acknowledged next cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_reg            <= '0;
			action_ack_o       <= 1'b0;
			desc_abort_close_o <= 1'b0;
		end else begin
			if (ar_event)
				cfg_reg <= cfg_i;
			action_ack_o       <= ar_event;
			desc_abort_close_o <= ar_event && cfg_i.fast_abort;
		end
	end

	// dma requests stop only for descriptor hold
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			data_req_o <= 1'b0;
		else
			data_req_o <= !desc_hold_i;
	end

	// one-byte holding latch; normal abort freezes buffer reads from the edge that loads it
	assign take = in_valid_i && in_ready_o;
	assign staged_valid_next = (staged_valid_reg && !(oct_end && take_data)) || take;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			staged_valid_reg <= 1'b0;
			staged_reg       <= '0;
			in_ready_o       <= 1'b0;
		end else begin
			staged_valid_reg <= staged_valid_next;
			if (take)
				staged_reg <= in_byte_i;
			in_ready_o <= !staged_valid_next
				&& !(ar_event ? cfg_i.normal_abort : cfg_reg.normal_abort);
		end
	end

	assign insert_zero = bit_en_i && content_reg && stuff_now;
	assign oct_end     = bit_en_i && !insert_zero && (bits_left_reg == 3'h0);
	assign start_ok    = staged_valid_reg && !cfg_reg.channel_tx_hold_cmd
		&& !cfg_reg.normal_abort;

	// octet sequencer, decided at the boundary of the octet on the line
	always_comb begin
		state_next  = state_reg;
		gap_next    = gap_reg;
		oct_val     = fill_char(cfg_reg);
		oct_content = 1'b0;
		take_data   = 1'b0;
		frame_start = 1'b0;
		evt_next    = EVT_NONE;
		unique case (state_reg)
			ST_FILL: begin
				if (cfg_reg.transparent) begin
					if (start_ok && gap_reg == 8'h00)
						take_data = 1'b1;
					else if (cfg_reg.channel_tx_hold_cmd)
						gap_next = 8'h00;
					else if (gap_reg != 8'h00)
						gap_next = gap_reg - 8'h01;
				end else if (start_ok) begin
					oct_val     = `TXF_FLAG_CHAR;
					state_next  = ST_DATA;
					frame_start = 1'b1;
				end
			end
			ST_DATA: begin
				if (cfg_reg.normal_abort) begin
					if (!cfg_reg.transparent)
						oct_val = `TXF_ABORT_CHAR;
					evt_next   = EVT_ABORT_CMD;
					state_next = ST_FILL;
				end else if (cfg_reg.transparent && cfg_reg.channel_tx_hold_cmd) begin
					state_next = ST_FILL;
				end else if (staged_valid_reg) begin
					take_data = 1'b1;
				end else begin
					if (!cfg_reg.transparent)
						oct_val = `TXF_ABORT_CHAR;
					evt_next   = EVT_ABORT_UNDERRUN;
					state_next = ST_FILL;
				end
			end
			ST_LAST: begin
				oct_val    = `TXF_FLAG_CHAR;
				evt_next   = EVT_FRAME_END;
				state_next = ST_GAP;
				gap_next   = adj_fill(cfg_reg.flag_adjust_enable, frame_fill_reg, zero_count);
			end
			ST_GAP: begin
				if (gap_reg > 8'h01) begin
					gap_next = gap_reg - 8'h01;
				end else if (gap_reg == 8'h01) begin
					oct_val  = `TXF_FLAG_CHAR;
					gap_next = 8'h00;
				end else if (start_ok) begin
					take_data   = 1'b1;
					frame_start = 1'b1;
				end else begin
					state_next = ST_FILL;
				end
			end
		endcase
		if (take_data) begin
			oct_val     = staged_reg.data;
			oct_content = !cfg_reg.transparent;
			state_next  = ST_DATA;
			if (staged_reg.frame_end_bit) begin
				if (cfg_reg.transparent) begin
					state_next = ST_FILL;
					evt_next   = EVT_FRAME_END;
					gap_next   = staged_reg.interframe_fill_count;
				end else begin
					state_next = ST_LAST;
				end
			end
		end
	end

	// sequencer state and per-frame fill count
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg      <= ST_FILL;
			gap_reg        <= 8'h00;
			frame_fill_reg <= 8'h00;
		end else if (oct_end) begin
			state_reg <= state_next;
			gap_reg   <= gap_next;
			if (take_data)
				frame_fill_reg <= staged_reg.interframe_fill_count;
		end
	end

	// bit shifter, lsb first; a stuffed zero holds the octet in place
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_bit_o      <= 1'b1;
			shift_reg     <= 8'h00;
			bits_left_reg <= 3'h0;
			content_reg   <= 1'b0;
		end else if (insert_zero) begin
			tx_bit_o <= 1'b0;
		end else if (oct_end) begin
			tx_bit_o      <= oct_val[0];
			shift_reg     <= {1'b0, oct_val[7:1]};
			bits_left_reg <= `TXF_OCT_BITS;
			content_reg   <= oct_content;
		end else if (bit_en_i) begin
			tx_bit_o      <= shift_reg[0];
			shift_reg     <= {1'b0, shift_reg[7:1]};
			bits_left_reg <= bits_left_reg - 3'h1;
		end
	end

	// events go to the queue writer tagged with this channel
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_valid_o   <= 1'b0;
			evt_code_o    <= EVT_NONE;
			evt_channel_o <= `TXF_RST_CHAN;
		end else begin
			evt_valid_o   <= oct_end && (evt_next != EVT_NONE);
			evt_code_o    <= oct_end ? evt_next : EVT_NONE;
			evt_channel_o <= CHANNEL_ID;
		end
	end

	zero_insert_tracker #(
		.CNT_W (8)
	) u_zero (
		.core_clk_i    (core_clk_i),
		.rst_i         (rst_i),
		.sent_i        (bit_en_i && !insert_zero),
		.bit_i         (oct_end ? oct_val[0] : shift_reg[0]),
		.content_i     (oct_end ? oct_content : content_reg),
		.stuffed_i     (insert_zero),
		.frame_start_i (oct_end && frame_start),
		.stuff_now_o   (stuff_now),
		.zero_count_o  (zero_count)
	);

	a_ack_after_ar: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ar_event |=> action_ack_o ##1 !action_ack_o) else $error("no single ack after request");
	a_fast_abort_close: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(ar_event && cfg_i.fast_abort) |=> desc_abort_close_o) else $error("fast abort not closed");
	a_abort_no_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cfg_reg.normal_abort |-> !in_ready_o) else $error("buffer read during abort");
	a_slot_hold_fill: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(oct_end && cfg_reg.transparent && cfg_reg.channel_tx_hold_cmd) |-> !take_data
		&& oct_val == fill_char(cfg_reg)) else $error("data sent under slot hold");
	a_stuff_after_five: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(bit_en_i && content_reg && stuff_now) |=> !tx_bit_o) else $error("missing zero insertion");
	a_no_stuff_fill: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(bit_en_i && !content_reg && bits_left_reg != 3'h0) |=> tx_bit_o == $past(shift_reg[0]))
		else $error("fill altered");
	a_frame_end_evt: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(oct_end && state_reg == ST_LAST) |=> evt_valid_o && evt_code_o == EVT_FRAME_END
		&& evt_channel_o == CHANNEL_ID) else $error("frame end event missing");
	a_gap_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(oct_end && state_reg == ST_LAST && !cfg_reg.flag_adjust_enable)
		|=> gap_reg == $past(frame_fill_reg)) else $error("fill count not used directly");
	a_gap_clamp: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(oct_end && state_reg == ST_LAST && cfg_reg.flag_adjust_enable
		&& (zero_count >> 3) >= frame_fill_reg) |=> gap_reg == 8'h00) else $error("no clamp");
	a_slot_fe_fill: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(oct_end && take_data && cfg_reg.transparent && staged_reg.frame_end_bit)
		|=> state_reg == ST_FILL) else $error("slot stream not stopped");
	a_desc_hold_req: assert property (@(posedge core_clk_i) disable iff (rst_i)
		desc_hold_i |=> !data_req_o) else $error("requests under descriptor hold");

	c_frame_end: cover property (@(posedge core_clk_i) disable iff (rst_i)
		evt_valid_o && evt_code_o == EVT_FRAME_END);
	c_underrun: cover property (@(posedge core_clk_i) disable iff (rst_i)
		evt_valid_o && evt_code_o == EVT_ABORT_UNDERRUN);
	c_shared_flag: cover property (@(posedge core_clk_i) disable iff (rst_i)
		oct_end && state_reg == ST_GAP && take_data);
	c_stuffed: cover property (@(posedge core_clk_i) disable iff (rst_i) insert_zero);
endmodule : channel_tx_formatter_hold
`default_nettype wire

// ---- dv/line_peer_model.sv ----
// peer station model: makes the time-slot bit strobe and records the line
`timescale 1ns/1ps
`default_nettype none
module line_peer_model #(
	parameter int DIV = 3
) (
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	// serial line
	output logic              bit_en_o,
	input  wire logic         tx_bit_i,
	// captured stream, newest bit in bit 0 of the history and in bit 7 of the octet
	output logic [127:0]      hist_o,
	output logic [7:0]        octet_o
);
	int         div_cnt;
	logic       smp;
	logic [2:0] bit_cnt;
	logic [7:0] sr;
	// one strobe every DIV cycles; the line bit is registered, so sample a cycle later
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt  <= 0;
			bit_en_o <= 1'b0;
			smp      <= 1'b0;
		end else begin
			div_cnt  <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
			bit_en_o <= (div_cnt == DIV - 1);
			smp      <= bit_en_o;
		end
	end
	// octets framed by bit count from reset; only valid until a stuffed frame shifts them
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hist_o  <= '1;
			sr      <= 8'hFF;
			bit_cnt <= 3'h0;
			octet_o <= 8'hFF;
		end else if (smp) begin
			hist_o  <= {hist_o[126:0], tx_bit_i};
			sr      <= {tx_bit_i, sr[7:1]};
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7)
				octet_o <= {tx_bit_i, sr[7:1]}; // lsb of each octet first
		end
	end
endmodule : line_peer_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the channel transmit formatter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tx_fmt_pkg::*;
	localparam logic [4:0] CHID = 5'h13; // arbitrary channel number
	typedef struct packed {logic tr; logic fa; logic sel; logic [7:0] ch; logic [7:0] exp;} row_s;
	row_s       rows [4] = '{'{1'h0, 1'h0, 1'h0, 8'h00, 8'h7E}, '{1'h0, 1'h0, 1'h1, 8'h00, 8'hFF},
	                         '{1'h1, 1'h0, 1'h0, 8'h5A, 8'hFF}, '{1'h1, 1'h1, 1'h0, 8'h5A, 8'h5A}};
	logic       core_clk = 1'b0;
	logic       rst, ar_n, ack, close, desc_hold, data_req, in_valid, in_ready, bit_en, tx_bit;
	logic       evt_valid;
	logic [4:0] evt_chan;
	logic [7:0] octet;
	logic [127:0] hist;
	cfg_s       cfg;
	tx_byte_s   in_byte;
	tx_evt_e    evt_code;
	tx_evt_e    last_evt = EVT_NONE;
	int         errors = 0, n_tests = 0, cyc = 0, n_under = 0;
	channel_tx_formatter_hold #(.CHANNEL_ID(CHID)) dut (.core_clk_i(core_clk), .rst_i(rst),
		.action_request_pulse_n_i(ar_n), .cfg_i(cfg), .action_ack_o(ack),
		.desc_abort_close_o(close), .desc_hold_i(desc_hold), .data_req_o(data_req),
		.in_valid_i(in_valid), .in_byte_i(in_byte), .in_ready_o(in_ready), .bit_en_i(bit_en),
		.tx_bit_o(tx_bit), .evt_valid_o(evt_valid), .evt_code_o(evt_code),
		.evt_channel_o(evt_chan));
	line_peer_model #(.DIV(3)) peer (.core_clk_i(core_clk), .rst_i(rst), .bit_en_o(bit_en),
		.tx_bit_i(tx_bit), .hist_o(hist), .octet_o(octet));
	always #2 core_clk = ~core_clk;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("errors %0d, comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// a hang counts as a mismatch and ends the run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			wrap_up();
		end
	end
	// events are one-cycle pulses, so keep the last one
	always @(posedge core_clk) begin
		if (evt_valid === 1'b1) begin
			last_evt <= evt_code;
			if (evt_code == EVT_ABORT_UNDERRUN)
				n_under++;
			check(evt_chan, CHID);
		end
	end
	function automatic cfg_s mk(input logic tr, fa, sel, input logic [7:0] ch, input logic h, na, fb);
		return '{tr, fa, sel, ch, h, na, fb};
	endfunction : mk
	// true where any window of the history holds pat, oldest bit of pat first
	function automatic logic has(input logic [63:0] pat, input int len);
		logic [127:0] m;
		m = (128'h1 << len) - 128'h1;
		for (int i = 0; i <= 128 - len; i++) begin
			if (((hist >> i) & m) === {64'h0, pat})
				return 1'b1;
		end
		return 1'b0;
	endfunction : has
	task automatic bits(input int n);
		repeat (n * 3) @(posedge core_clk);
	endtask : bits
	// pin held low until the ack pulse, then idle high before the next action
	task automatic act(input cfg_s c);
		int k;
		cfg  <= c;
		ar_n <= 1'b0;
		k = 0;
		@(posedge core_clk);
		while (ack !== 1'b1 && k < 8) begin
			@(posedge core_clk);
			k++;
		end
		check(k < 8, 1);
		check(close, c.fast_abort);
		ar_n <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask : act
	// valid stays up after the take; caller lowers it with done
	task automatic send(input logic [7:0] d, input logic fe, input logic [7:0] n);
		int k;
		in_valid <= 1'b1;
		in_byte  <= '{d, fe, n};
		k = 0;
		@(posedge core_clk);
		while (in_ready !== 1'b1 && k < 400) begin
			@(posedge core_clk);
			k++;
		end
		check(k < 400, 1);
	endtask : send
	task automatic done;
		in_valid <= 1'b0;
	endtask : done
	initial begin
		rst = 1'b1;
		ar_n = 1'b1;
		cfg = '0;
		desc_hold = 1'b0;
		in_valid = 1'b0;
		in_byte = '0;
		repeat (8) @(posedge core_clk);
		check(tx_bit, 1);
		check(data_req, 0);
		rst <= 1'b0;
		desc_hold <= 1'b1;
		repeat (3) @(posedge core_clk);
		check(data_req, 0);
		check(evt_chan, CHID);
		desc_hold <= 1'b0;
		repeat (2) @(posedge core_clk);
		check(data_req, 1);
		// idle fill of every mode, before stuffing breaks octet alignment
		foreach (rows[i]) begin
			act(mk(rows[i].tr, rows[i].fa, rows[i].sel, rows[i].ch, 0, 0, 0));
			bits(24);
			check(octet, rows[i].exp);
		end
		act(mk(0, 0, 0, 8'h00, 0, 0, 0));
		send(8'hFF, 1, 0);
		done();
		bits(48);
		check(has({8'h7E, 9'h1F7, 8'h7E}, 25), 1);
		check(last_evt, EVT_FRAME_END);
		// gap of two against a shared flag, ones fill
		act(mk(0, 0, 1, 8'h00, 0, 0, 0));
		send(8'h00, 1, 2);
		send(8'h00, 1, 0);
		done();
		bits(64);
		check(has({8'h7E, 8'h00, 8'h7E, 8'hFF, 8'h7E, 8'h00, 8'h7E}, 56), 1);
		send(8'h00, 1, 0);
		send(8'h00, 1, 0);
		done();
		bits(56);
		check(has({8'h7E, 8'h00, 8'h7E, 8'h00, 8'h7E}, 40), 1);
		// eight insertions cut a count of one down to a shared flag
		act(mk(0, 1, 1, 8'h00, 0, 0, 0));
		repeat (4) send(8'hFF, 0, 0);
		send(8'hFF, 1, 1);
		send(8'h00, 1, 0);
		done();
		bits(96);
		check(has({5'h1F, 1'h0, 8'h7E, 8'h00, 8'h7E}, 30), 1);
		// transparent: stop after frame end, then hold keeps data off the line
		act(mk(1, 0, 0, 8'h00, 0, 0, 0));
		send(8'h01, 1, 0);
		done();
		bits(40);
		check(has({8'h80, 8'hFF, 8'hFF}, 24), 1);
		act(mk(1, 0, 0, 8'h00, 1, 0, 0)); // hold issued only while the line idles
		send(8'h00, 1, 5);
		done();
		bits(64);
		check(hist[63:0], 64'hFFFF_FFFF_FFFF_FFFF);
		act(mk(1, 0, 0, 8'h00, 0, 0, 0));
		bits(40);
		check(has({8'hFF, 8'h00, 8'hFF}, 24), 1);
		// normal abort in mid-frame, then fast abort, then two underruns
		act(mk(0, 0, 0, 8'h00, 0, 0, 0));
		send(8'h00, 0, 0);
		send(8'h00, 0, 0);
		done();
		act(mk(0, 0, 0, 8'h00, 0, 1, 0));
		bits(32);
		check(last_evt, EVT_ABORT_CMD);
		check(in_ready, 0);
		check(has({8'hFE, 8'h7E}, 16), 1);
		act(mk(0, 0, 0, 8'h00, 0, 0, 1));
		bits(64);
		check(n_under, 1);
		send(8'h00, 0, 0);
		done();
		bits(64);
		check(last_evt, EVT_ABORT_UNDERRUN);
		check(n_under, 2);
		// reset in mid-run: outputs go idle, then flag fill of the reset mode resumes
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		check(tx_bit, 1);
		check(in_ready, 0);
		check(evt_valid, 0);
		check(data_req, 0);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		check(in_ready, 1);
		bits(24);
		check(octet, 8'h7E);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
